/* File: tps_pkg.sv */
// What this block does
// - priority register bits 5..1 hold a 5-bit rank, 0x00 highest, 0x1f lowest.
// - switch to valid inactive profile that outranks the active one by more than seven.
// - difference of zero through seven keeps the loop on the active profile.
// - enable bit zero; while clear the profile is never selected or used.
// - source bits 4..0 pick reference a, its complement, b, its complement, or feedback.
`default_nettype none
package tps_pkg;
   // register bus geometry
   localparam int ADDR_W = 16;
   localparam int DATA_W = 8;
   // register offsets
   localparam logic [15:0] OFS_PRIORITY_ENABLE = 16'h1200;
   localparam logic [15:0] OFS_INPUT_SOURCE = 16'h1201;
   localparam logic [15:0] OFS_PROFILE_STATUS = 16'h12f0;
   // field positions of the priority and enable register
   localparam int FLD_ENABLE = 0;
   localparam int FLD_PRIO_LSB = 1;
   localparam int FLD_PRIO_MSB = 5;
   localparam int PRIO_W = 5;
   // field positions of the source register
   localparam int FLD_SRC_LSB = 0;
   localparam int FLD_SRC_MSB = 4;
   localparam int SRC_W = 5;
   // field positions of the status register
   localparam int FLD_ST_SWITCH = 0;
   localparam int FLD_ST_UNSUP = 1;
   localparam int FLD_ST_USABLE = 2;
   localparam int FLD_ST_ACTIVE = 3;
   // reset values
   localparam logic [PRIO_W-1:0] RST_PRIORITY = 5'h00;
   localparam logic RST_ENABLE = 1'b0;
   localparam logic [SRC_W-1:0] RST_SOURCE = 5'h00;
   // rank ordering limits and switching threshold
   localparam logic [PRIO_W-1:0] PRIO_HIGHEST = 5'h00;
   localparam logic [PRIO_W-1:0] PRIO_LOWEST = 5'h1f;
   localparam logic [PRIO_W-1:0] REVERT_GAP = 5'h07;
   // number of selectable inputs
   localparam int NUM_SRC = 5;
   // source codes
   typedef enum logic [SRC_W-1:0]
   {
      TPS_SRC_REF_A = 5'h00,
      TPS_SRC_REF_A_COMP = 5'h01,
      TPS_SRC_REF_B = 5'h02,
      TPS_SRC_REF_B_COMP = 5'h03,
      TPS_SRC_LOOP_FEEDBACK = 5'h05
   } tps_src_code_t;
   // one-hot input select bit positions
   localparam int SEL_REF_A = 0;
   localparam int SEL_REF_A_COMP = 1;
   localparam int SEL_REF_B = 2;
   localparam int SEL_REF_B_COMP = 3;
   localparam int SEL_LOOP_FEEDBACK = 4;
   // register bus request and answer
   typedef struct packed
   {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } tps_bus_req_t;
   typedef struct packed
   {
      logic [DATA_W-1:0] rdata;
   } tps_bus_rsp_t;
   // state reported by the loop state machine about this profile
   typedef struct packed
   {
      logic valid;
      logic active;
      logic [PRIO_W-1:0] active_priority;
   } tps_loop_state_t;
   // configuration and decision handed to the loop
   typedef struct packed
   {
      logic enable;
      logic [PRIO_W-1:0] priority_rank;
      logic [NUM_SRC-1:0] source_select;
      logic source_unsupported;
      logic usable;
      logic switch_request;
   } tps_profile_out_t;
endpackage : tps_pkg
`default_nettype wire

/* File: tps_rank_judge.sv */
`timescale 1ns/10ps
`default_nettype none
module tps_rank_judge
#(
   parameter int PRIO_W = 5,
   parameter logic [PRIO_W-1:0] GAP = 5'h07
)
(
   input wire logic [PRIO_W-1:0] own_rank,
   input wire logic [PRIO_W-1:0] active_rank,
   input wire logic candidate,
   output logic take_over
);
   logic outranks;
   logic [PRIO_W-1:0] rank_gap;

   // refuse widths the subtraction cannot serve
   generate
      if (PRIO_W < 1 || PRIO_W > 8)
      begin : g_bad_width
         $error("tps_rank_judge: PRIO_W out of range");
      end
   endgenerate

   // lower value ranks higher; gap only meaningful when own rank is higher
   assign outranks = own_rank < active_rank;
   assign rank_gap = active_rank - own_rank;
   // a gap of seven or less keeps the active profile, more reverts
   assign take_over = candidate & outranks & (rank_gap > GAP);
endmodule : tps_rank_judge
`default_nettype wire

/* File: tps_profile_regs.sv */
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
module tps_profile_regs
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire tps_pkg::tps_bus_req_t bus_req,
   output tps_pkg::tps_bus_rsp_t bus_rsp,
   input wire tps_pkg::tps_loop_state_t loop_state,
   output tps_pkg::tps_profile_out_t profile_out
);
   import tps_pkg::*;

   // stored fields
   logic enable;
   logic [PRIO_W-1:0] priority_rank;
   logic [SRC_W-1:0] source_code;

   // decoded register hits
   wire hit_prio = bus_req.addr == OFS_PRIORITY_ENABLE;
   wire hit_src = bus_req.addr == OFS_INPUT_SOURCE;
   wire hit_status = bus_req.addr == OFS_PROFILE_STATUS;
   wire wr_prio = bus_req.wr & hit_prio;
   wire wr_src = bus_req.wr & hit_src;

   // next values of stored fields; reserved bits never reach a flop
   wire [PRIO_W-1:0] next_priority_rank = bus_req.wdata[FLD_PRIO_MSB:FLD_PRIO_LSB];
   wire next_enable = bus_req.wdata[FLD_ENABLE];
   wire [SRC_W-1:0] next_source_code = bus_req.wdata[FLD_SRC_MSB:FLD_SRC_LSB];

   // source decode: only listed codes drive a select line
   logic [NUM_SRC-1:0] src_onehot;
   logic src_listed;
   always_comb
   begin
      src_onehot = '0;
      src_listed = 1'b1;
      case (source_code)
         TPS_SRC_REF_A: src_onehot[SEL_REF_A] = 1'b1;
         TPS_SRC_REF_A_COMP: src_onehot[SEL_REF_A_COMP] = 1'b1;
         TPS_SRC_REF_B: src_onehot[SEL_REF_B] = 1'b1;
         TPS_SRC_REF_B_COMP: src_onehot[SEL_REF_B_COMP] = 1'b1;
         TPS_SRC_LOOP_FEEDBACK: src_onehot[SEL_LOOP_FEEDBACK] = 1'b1;
         default: src_listed = 1'b0; // codes 4 and 6..31
      endcase
   end

   // a disabled profile or an unsupported source is never offered to the loop
   wire usable = enable & src_listed;
   wire candidate = usable & loop_state.valid & ~loop_state.active;
   wire take_over;

   // revertive versus nonrevertive decision
   tps_rank_judge
   #(
      .PRIO_W(PRIO_W),
      .GAP(REVERT_GAP)
   )
   u_judge
   (
      .own_rank(priority_rank),
      .active_rank(loop_state.active_priority),
      .candidate(candidate),
      .take_over(take_over)
   );

   // select lines stay low while the profile cannot be used
   wire [NUM_SRC-1:0] next_select = enable ? src_onehot : '0;

   // read mux; reserved bits and unmapped offsets read zero
   wire [DATA_W-1:0] rd_prio = {2'h0, priority_rank, enable};
   wire [DATA_W-1:0] rd_src = {3'h0, source_code};
   wire [DATA_W-1:0] rd_status = {4'h0, loop_state.active, usable, ~src_listed,
                                  profile_out.switch_request};
   wire [DATA_W-1:0] next_rdata = hit_prio ? rd_prio :
                                  hit_src ? rd_src :
                                  hit_status ? rd_status : 8'h00;

   // priority and enable register
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         priority_rank <= RST_PRIORITY;
         enable <= RST_ENABLE;
      end
      else if (wr_prio)
      begin
         priority_rank <= next_priority_rank;
         enable <= next_enable;
      end
   end

   // source register; unlisted codes are kept so software reads back what it wrote
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         source_code <= RST_SOURCE;
      end
      else if (wr_src)
      begin
         source_code <= next_source_code;
      end
   end

   // read data valid in the cycle after the strobe only
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         bus_rsp.rdata <= 8'h00;
      end
      else
      begin
         bus_rsp.rdata <= bus_req.rd ? next_rdata : 8'h00;
      end
   end

   // registered outputs to the loop; one cycle behind the register contents
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         profile_out <= '0;
      end
      else
      begin
         profile_out.enable <= enable;
         profile_out.priority_rank <= priority_rank;
         profile_out.source_select <= next_select;
         profile_out.source_unsupported <= ~src_listed;
         profile_out.usable <= usable;
         profile_out.switch_request <= take_over;
      end
   end
endmodule : tps_profile_regs
`default_nettype wire

/* File: tps_profile_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
module tps_profile_monitor
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire tps_pkg::tps_bus_req_t bus_req,
   input wire tps_pkg::tps_bus_rsp_t bus_rsp,
   input wire tps_pkg::tps_loop_state_t loop_state,
   input wire tps_pkg::tps_profile_out_t profile_out
);
   import tps_pkg::*;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   // read decodes seen by the monitor
   wire logic rd_prio = bus_req.rd && bus_req.addr == OFS_PRIORITY_ENABLE;
   wire logic rd_src = bus_req.rd && bus_req.addr == OFS_INPUT_SOURCE;
   // expected one-hot select for a listed code
   function automatic logic [4:0] sel_of(input logic [4:0] c);
      sel_of = c < 5'h04 ? 5'h01 << c : (c == 5'h05 ? 5'h10 : 5'h00);
   endfunction : sel_of
   // rank taken against last cycle's loop state, since switch_request is a flop
   sequence take;
      profile_out.usable && $past(loop_state.valid) && !$past(loop_state.active) &&
      $past(loop_state.active_priority) > profile_out.priority_rank &&
      $past(loop_state.active_priority) - profile_out.priority_rank > 5'h07;
   endsequence
   AST_RDATA_IDLE: assert property (!bus_req.rd |=> bus_rsp.rdata == 8'h00)
      else $error("read data not zero outside read answer");
   AST_RD_PRIO: assert property (rd_prio |=> bus_rsp.rdata == {2'b00, profile_out.priority_rank, profile_out.enable})
      else $error("priority read does not match fields");
   AST_RD_SRC: assert property (rd_src |=> bus_rsp.rdata[7:5] == 3'b000)
      else $error("source reserved bits not zero");
   AST_SRC_MAP: assert property (rd_src |=> profile_out.source_select == (profile_out.enable ? sel_of(bus_rsp.rdata[4:0]) : 5'h00))
      else $error("source select does not match code");
   AST_UNSUP: assert property (profile_out.source_unsupported |-> profile_out.source_select == 5'h00 && !profile_out.usable)
      else $error("unsupported code still selects");
   AST_USABLE: assert property (profile_out.usable == (profile_out.enable && !profile_out.source_unsupported))
      else $error("usable flag wrong");
   AST_REVERT: assert property (take |-> profile_out.switch_request)
      else $error("missing switch request");
   AST_HOLD: assert property (profile_out.switch_request |-> take)
      else $error("switch request without cause");
   // main scenarios reached
   cover property (profile_out.switch_request);
   cover property (rd_src ##1 profile_out.source_unsupported);
   cover property (rd_prio ##1 bus_rsp.rdata != 8'h00);
endmodule : tps_profile_monitor
`default_nettype wire

/* File: tps_profile_regs_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module tps_profile_regs_tb;
   import tps_pkg::*;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   tps_bus_req_t q = '0;
   tps_bus_rsp_t r;
   tps_loop_state_t ls = '0;
   tps_profile_out_t po;
   int error_cnt = 0;
   int comparisons = 0;
   tps_profile_regs i_tps_profile_regs (.core_clk(core_clk), .rst_n(rst_n), .bus_req(q), .bus_rsp(r),
      .loop_state(ls), .profile_out(po));
   // 50 mhz clock
   initial
   begin
      forever #10 core_clk = ~core_clk;
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("wrong value at %0t: %h, expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic step(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : step
   // strobe released at the next edge, so a following call starts a cycle later
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge core_clk) q <= '{a, d, 1'b1, 1'b0};
      @(posedge core_clk) q <= '0;
   endtask : wr
   task automatic rd(input logic [15:0] a, input logic [7:0] e);
      @(posedge core_clk) q <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge core_clk) q <= '0;
      #1 chk(r.rdata, e);
   endtask : rd
   task automatic sw(input logic v, input logic a, input logic [4:0] ap, input logic e);
      @(posedge core_clk) ls <= '{v, a, ap};
      step(2);
      chk({7'h00, po.switch_request}, {7'h00, e});
   endtask : sw
   task automatic close_out();
      $display("mismatches %0d, comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : close_out
   // reset values, reserved bits and an unmapped place
   task automatic t_regs();
      rd(16'h1200, 8'h00);
      rd(16'h1202, 8'h00);
      wr(16'h1200, 8'hff);
      rd(16'h1200, 8'h3f);
      chk({3'b000, po.priority_rank}, 8'h1f);
      chk({7'h00, po.enable}, 8'h01);
      wr(16'h1201, 8'hff);
      rd(16'h1201, 8'h1f);
      step(1);
      chk({7'h00, po.source_unsupported}, 8'h01);
      // status: unsupported source, not usable, no switch while loop state is idle
      rd(16'h12f0, 8'h02);
   endtask : t_regs
   // source codes 0 through 7 with the profile enabled
   task automatic t_src();
      logic [4:0] e;
      wr(16'h1200, 8'h01);
      for (int c = 0; c < 8; c++)
      begin
         e = c < 4 ? 5'h01 << c : (c == 5 ? 5'h10 : 5'h00);
         wr(16'h1201, 8'(c));
         rd(16'h1201, 8'(c));
         chk({3'b000, po.source_select}, {3'b000, e});
         chk({7'h00, po.usable}, {7'h00, e != 5'h00});
      end
   endtask : t_src
   // gap boundaries, active and invalid cases, disable, then gap boundaries again at rank zero
   task automatic t_switch();
      wr(16'h1201, 8'h00);
      wr(16'h1200, 8'h07);
      sw(1'b1, 1'b0, 5'd11, 1'b1);
      // status: switch request and usable set, not active
      rd(16'h12f0, 8'h05);
      sw(1'b1, 1'b0, 5'd10, 1'b0);
      sw(1'b1, 1'b0, 5'd3, 1'b0);
      sw(1'b1, 1'b1, 5'd31, 1'b0);
      sw(1'b0, 1'b0, 5'd31, 1'b0);
      sw(1'b1, 1'b0, 5'd31, 1'b1);
      wr(16'h1200, 8'h06);
      step(2);
      chk({7'h00, po.switch_request}, 8'h00);
      wr(16'h1200, 8'h01);
      sw(1'b1, 1'b0, 5'd8, 1'b1);
      sw(1'b1, 1'b0, 5'd7, 1'b0);
   endtask : t_switch
   // main sequence
   initial
   begin
      repeat (6) @(posedge core_clk);
      rst_n <= 1'b1;
      t_regs();
      t_src();
      t_switch();
      close_out();
   end
   // watchdog, far beyond the roughly 91 cycles needed
   initial
   begin
      #50000;
      error_cnt++;
      close_out();
   end
endmodule : tps_profile_regs_tb
bind tps_profile_regs tps_profile_monitor i_tps_profile_monitor (.core_clk(core_clk), .rst_n(rst_n),
   .bus_req(bus_req), .bus_rsp(bus_rsp), .loop_state(loop_state), .profile_out(profile_out));
`default_nettype wire
